// ---- logic/psc_pkg.sv ----
/*
  Constants, register map and types of the programmable stage comparator.
  Assumes one 25 MHz clock; values are signed, relative pick-up and hysteresis in ppm.
*/
package psc_pkg;
  // ==========================================================
  // widths
  localparam int DW       = 32;
  localparam int AW       = 8;
  localparam int NMAG     = 3;
  localparam int FRAC     = 16;
  // ==========================================================
  // register map
  localparam logic [7:0] OFF_CTRL     = 8'h00;
  localparam logic [7:0] OFF_OP_DLY   = 8'h04;
  localparam logic [7:0] OFF_REL_DLY  = 8'h08;
  localparam logic [7:0] OFF_INT_STAT = 8'h0C;
  localparam logic [7:0] OFF_INT_MASK = 8'h10;
  localparam logic [7:0] OFF_COND     = 8'h14;
  localparam logic [7:0] OFF_EXP_TIME = 8'h18;
  localparam logic [7:0] OFF_REM_TIME = 8'h1C;
  localparam logic [7:0] OFF_CALC_PU  = 8'h20;
  localparam logic [7:0] OFF_CALC_RAT = 8'h24;
  // magnitude blocks at 0x80 + 0x20*i, word index within block
  localparam logic [2:0] MR_SCALE  = 3'h0;
  localparam logic [2:0] MR_PICKUP = 3'h1;
  localparam logic [2:0] MR_MODE   = 3'h2;
  localparam logic [2:0] MR_HYST   = 3'h3;
  localparam logic [2:0] MR_SCALED = 3'h4;
  localparam logic [2:0] MR_RATIO  = 3'h5;
  // ==========================================================
  // reset values
  localparam logic [31:0] SCALE_ONE  = 32'h0001_0000;
  localparam logic [31:0] PICKUP_DEF = 32'h0000_0064;
  localparam logic [31:0] HYST_DEF   = 32'h0000_7530;
  localparam logic [31:0] OP_DEF     = 32'h0000_0008;
  localparam logic [31:0] REL_DEF    = 32'h0000_000C;
  localparam logic [31:0] DELAY_MAX  = 32'h0005_7E40;
  localparam logic [1:0]  COUNT_DEF  = 2'h1;
  localparam logic [63:0] PPM_FULL   = 64'h0000_0000_000F_4240;
  // ==========================================================
  // timing
  localparam int STEP_US   = 5000;
  localparam int CLK_MHZ   = 25;
  localparam int STEP_CYC  = STEP_US * CLK_MHZ;
  localparam int STEP_MS   = STEP_US / 1000;
  localparam int DELTA_MS  = 20;
  localparam int DELTA_STP = DELTA_MS / STEP_MS;
  // ==========================================================
  // interrupt bits and bus answers
  localparam int IRQ_START = 0;
  localparam int IRQ_TRIP  = 1;
  localparam int IRQ_BLOCK = 2;
  localparam int IRQ_W     = 3;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    CM_OVER, CM_OVER_ABS, CM_UNDER, CM_UNDER_ABS,
    CM_DREL_SGN, CM_DREL_ABS, CM_DELTA_SGN, CM_DELTA_ABS
  } psc_mode_t;
  typedef enum logic [3:0] {
    ST_NORMAL  = 4'b0001,
    ST_START   = 4'b0010,
    ST_TRIP    = 4'b0100,
    ST_BLOCKED = 4'b1000
  } psc_cond_t;
endpackage

// ---- logic/psc_compare.sv ----
/*
  One magnitude comparator with relative reset hysteresis and delta modes.
  Assumes delta_tick pulses once per 20 ms window on the same clock.
*/
`timescale 1ns/1ns
module psc_compare
  import psc_pkg::*;
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          delta_tick,
  input  wire logic [31:0]   value,
  input  wire logic [31:0]   pickup,
  input  wire logic [2:0]    mode,
  input  wire logic [31:0]   hyst,
  output logic               hit
);
  logic signed [31:0] prev_q;
  logic signed [32:0] delta_q;
  logic signed [31:0] base_q;
  logic signed [63:0] v;
  logic signed [63:0] pk;
  logic signed [63:0] band;
  logic signed [63:0] eff;
  logic signed [63:0] m;
  logic signed [63:0] thr;
  logic               under;
  logic               rel;
  logic               hit_d;

  function automatic logic signed [63:0] abs64(input logic signed [63:0] x);
    abs64 = x < 0 ? -x : x;
  endfunction

  // ==========================================================
  // 20 ms change window
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      prev_q  <= '0;
      delta_q <= '0;
      base_q  <= '0;
    end
    else if (delta_tick)
    begin
      prev_q  <= value;
      base_q  <= prev_q;
      delta_q <= 33'(signed'(value)) - 33'(prev_q);
    end
  end

  // ==========================================================
  // metric, threshold and hysteresis
  always_comb
  begin
    v     = 64'(signed'(value));
    pk    = 64'(signed'(pickup));
    rel   = 1'b0;
    under = 1'b0;
    m     = v;
    case (psc_mode_t'(mode))
      CM_OVER:      m = v;
      CM_OVER_ABS:  m = abs64(v);
      CM_UNDER:     under = 1'b1;
      CM_UNDER_ABS:
      begin
        m     = abs64(v);
        under = 1'b1;
      end
      CM_DREL_SGN:
      begin
        rel   = 1'b1;
        m     = 64'(delta_q) * signed'(PPM_FULL);
        under = pk < 0;
      end
      CM_DREL_ABS:
      begin
        rel = 1'b1;
        m   = abs64(64'(delta_q)) * signed'(PPM_FULL);
        pk  = abs64(pk);
      end
      CM_DELTA_SGN:
      begin
        m     = 64'(delta_q);
        under = pk < 0;
      end
      CM_DELTA_ABS:
      begin
        m  = abs64(64'(delta_q));
        pk = abs64(pk);
      end
      default:      m = v;
    endcase
    band = abs64(pk) * signed'(64'(hyst)) / signed'(PPM_FULL);
    if (!hit)
      eff = pk;
    else if (under)
      eff = pk + band;
    else
      eff = pk - band;
    thr   = rel ? eff * abs64(64'(base_q)) : eff;
    hit_d = under ? (m < thr) : (m > thr);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      hit <= 1'b0;
    else
      hit <= hit_d;
  end
endmodule // psc_compare

// ---- logic/psc_stage.sv ----
/*
  Programmable protection stage: AXI4-Lite registers, three scaled
  magnitude comparators, start/trip/blocked timing and interrupt.
  Assumes measurements and the block input come from logic on aclk.
*/
// The implementer's own choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ns
module psc_stage
  import psc_pkg::*;
#(
  parameter int STEP_CYCLES = STEP_CYC
)
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [NMAG*DW-1:0] meas_in,
  input  wire logic               block_in,
  input  wire logic [AW-1:0]      s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [DW-1:0]      s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [AW-1:0]      s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [DW-1:0]           s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  output logic                    start_out,
  output logic                    trip_out,
  output logic                    blocked_out,
  output logic                    irq
);
  // ==========================================================
  // declarations
  logic [1:0]         count_q;
  logic [31:0]        op_dly_q;
  logic [31:0]        rel_dly_q;
  logic [31:0]        calc_pu_q;
  logic [31:0]        scale_q [NMAG];
  logic [31:0]        pickup_q [NMAG];
  logic [2:0]         mode_q [NMAG];
  logic [31:0]        hyst_q [NMAG];
  logic [31:0]        scaled_q [NMAG];
  logic [31:0]        ratio_q [NMAG];
  logic [31:0]        calc_rat_q;
  logic [NMAG-1:0]    hit;
  logic [NMAG-1:0]    sel;
  logic [IRQ_W-1:0]   stat_q;
  logic [IRQ_W-1:0]   mask_q;
  logic [IRQ_W-1:0]   ev;
  psc_cond_t          state_q;
  psc_cond_t          state_d;
  logic [31:0]        op_cnt_q;
  logic [31:0]        rel_cnt_q;
  logic [31:0]        exp_q;
  logic [31:0]        rem_q;
  logic [31:0]        div_q;
  logic [2:0]         dstep_q;
  logic               step_tick;
  logic               delta_tick;
  logic               pick;
  logic               timing;
  logic [AW-1:0]      awaddr_q;
  logic               aw_q;
  logic [DW-1:0]      wdata_q;
  logic [3:0]         wstrb_q;
  logic               w_q;
  logic               wr_en;
  logic               wr_ok;
  logic [DW-1:0]      rd_data;
  logic               rd_ok;
  logic signed [33:0] calc_sum;

  // ==========================================================
  // decoding helpers
  function automatic logic is_mag(input logic [AW-1:0] a);
    is_mag = a[7] && (a[6:5] != 2'h3) && (a[1:0] == 2'h0);
  endfunction

  function automatic logic [2:0] mag_reg(input logic [AW-1:0] a);
    mag_reg = a[4:2];
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++)
      merge[b*8 +: 8] = s[b] ? n[b*8 +: 8] : o[b*8 +: 8];
  endfunction

  function automatic logic [31:0] clamp_dly(input logic [31:0] x);
    clamp_dly = (x > DELAY_MAX) ? DELAY_MAX : x;
  endfunction

  function automatic logic [31:0] ratio(input logic [31:0] num, input logic [31:0] den);
    logic signed [63:0] n;
    n = 64'(signed'(num)) <<< FRAC;
    if (den == '0)
      ratio = '0;
    else
      ratio = 32'(n / 64'(signed'(den)));
  endfunction

  // ==========================================================
  // AXI4-Lite write channel
  assign s_axi_awready = !aw_q && !s_axi_bvalid;
  assign s_axi_wready  = !w_q && !s_axi_bvalid;
  assign wr_en         = aw_q && w_q && !s_axi_bvalid;
  assign wr_ok         = is_mag(awaddr_q) ? (mag_reg(awaddr_q) <= MR_RATIO)
                       : (awaddr_q <= OFF_CALC_RAT && awaddr_q[1:0] == 2'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q     <= 1'b0;
      w_q      <= 1'b0;
      awaddr_q <= '0;
      wdata_q  <= '0;
      wstrb_q  <= '0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      else if (wr_en)
        aw_q <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_q     <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      else if (wr_en)
        w_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end
    else if (wr_en)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // ==========================================================
  // settings
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      count_q   <= COUNT_DEF;
      op_dly_q  <= OP_DEF;
      rel_dly_q <= REL_DEF;
      calc_pu_q <= PICKUP_DEF;
      mask_q    <= '0;
      for (int i = 0; i < NMAG; i++)
      begin
        scale_q[i]  <= SCALE_ONE;
        pickup_q[i] <= PICKUP_DEF;
        mode_q[i]   <= CM_OVER;
        hyst_q[i]   <= HYST_DEF;
      end
    end
    else if (wr_en)
    begin
      if (is_mag(awaddr_q))
        case (mag_reg(awaddr_q))
          MR_SCALE:  scale_q[awaddr_q[6:5]] <=
                       merge(scale_q[awaddr_q[6:5]], wdata_q, wstrb_q);
          MR_PICKUP: pickup_q[awaddr_q[6:5]] <=
                       merge(pickup_q[awaddr_q[6:5]], wdata_q, wstrb_q);
          MR_MODE:   if (wstrb_q[0])
                       mode_q[awaddr_q[6:5]] <= wdata_q[2:0];
          MR_HYST:   hyst_q[awaddr_q[6:5]] <=
                       merge(hyst_q[awaddr_q[6:5]], wdata_q, wstrb_q);
          default:   ;
        endcase
      else
        case (awaddr_q)
          OFF_CTRL:     if (wstrb_q[0])
                          count_q <= wdata_q[1:0];
          OFF_OP_DLY:   op_dly_q <= clamp_dly(merge(op_dly_q, wdata_q, wstrb_q));
          OFF_REL_DLY:  rel_dly_q <= clamp_dly(merge(rel_dly_q, wdata_q, wstrb_q));
          OFF_INT_MASK: if (wstrb_q[0])
                          mask_q <= wdata_q[IRQ_W-1:0];
          OFF_CALC_PU:  calc_pu_q <= merge(calc_pu_q, wdata_q, wstrb_q);
          default:      ;
        endcase
    end
  end

  // ==========================================================
  // AXI4-Lite read channel
  always_comb
  begin
    rd_data = '0;
    rd_ok   = 1'b1;
    if (is_mag(s_axi_araddr))
      case (mag_reg(s_axi_araddr))
        MR_SCALE:  rd_data = scale_q[s_axi_araddr[6:5]];
        MR_PICKUP: rd_data = pickup_q[s_axi_araddr[6:5]];
        MR_MODE:   rd_data = 32'(mode_q[s_axi_araddr[6:5]]);
        MR_HYST:   rd_data = hyst_q[s_axi_araddr[6:5]];
        MR_SCALED: rd_data = scaled_q[s_axi_araddr[6:5]];
        MR_RATIO:  rd_data = ratio_q[s_axi_araddr[6:5]];
        default:   rd_ok = 1'b0;
      endcase
    else
      case (s_axi_araddr)
        OFF_CTRL:     rd_data = 32'(count_q);
        OFF_OP_DLY:   rd_data = op_dly_q;
        OFF_REL_DLY:  rd_data = rel_dly_q;
        OFF_INT_STAT: rd_data = 32'(stat_q);
        OFF_INT_MASK: rd_data = 32'(mask_q);
        OFF_COND:     rd_data = 32'(state_q);
        OFF_EXP_TIME: rd_data = exp_q;
        OFF_REM_TIME: rd_data = rem_q;
        OFF_CALC_PU:  rd_data = calc_pu_q;
        OFF_CALC_RAT: rd_data = calc_rat_q;
        default:      rd_ok = 1'b0;
      endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_data;
      s_axi_rresp  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ==========================================================
  // 5 ms step and 20 ms delta window
  assign step_tick  = (div_q == 32'(STEP_CYCLES - 1));
  assign delta_tick = step_tick && (dstep_q == 3'(DELTA_STP - 1));

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      div_q   <= '0;
      dstep_q <= '0;
    end
    else if (step_tick)
    begin
      div_q   <= '0;
      dstep_q <= delta_tick ? 3'h0 : dstep_q + 3'h1;
    end
    else
      div_q <= div_q + 32'h1;
  end

  // ==========================================================
  // scaling, comparison and ratios
  assign sel = (count_q == 2'h3) ? 3'h7 : (count_q == 2'h2) ? 3'h3 : 3'h1;

  generate
    for (genvar g = 0; g < NMAG; g++)
    begin : g_mag
      logic signed [63:0] prod;
      assign prod = 64'(signed'(meas_in[g*DW +: DW])) * 64'(signed'(scale_q[g]));

      always_ff @(posedge aclk)
      begin
        if (!aresetn)
        begin
          scaled_q[g] <= '0;
          ratio_q[g]  <= '0;
        end
        else
        begin
          scaled_q[g] <= 32'(prod >>> FRAC);
          ratio_q[g]  <= ratio(scaled_q[g], pickup_q[g]);
        end
      end

      psc_compare u_cmp (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .delta_tick (delta_tick),
        .value      (scaled_q[g]),
        .pickup     (pickup_q[g]),
        .mode       (mode_q[g]),
        .hyst       (hyst_q[g]),
        .hit        (hit[g])
      );
    end
  endgenerate

  assign calc_sum = (sel[0] ? 34'(signed'(scaled_q[0])) : 34'h0)
                  + (sel[1] ? 34'(signed'(scaled_q[1])) : 34'h0)
                  + (sel[2] ? 34'(signed'(scaled_q[2])) : 34'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      calc_rat_q <= '0;
    else
      calc_rat_q <= ratio(32'(calc_sum), calc_pu_q);
  end

  // ==========================================================
  // condition state machine
  assign pick   = |(hit & sel);
  assign timing = pick && !block_in;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_NORMAL:
        if (pick)
          state_d = block_in ? ST_BLOCKED : ST_START;
      ST_START:
        if (timing && op_cnt_q >= op_dly_q)
          state_d = ST_TRIP;
        else if (!timing && rel_cnt_q >= rel_dly_q)
          state_d = pick ? ST_BLOCKED : ST_NORMAL;
      ST_TRIP:
        if (!pick && rel_cnt_q >= rel_dly_q)
          state_d = ST_NORMAL;
      ST_BLOCKED:
        if (!pick)
          state_d = ST_NORMAL;
        else if (!block_in)
          state_d = ST_START;
      default: state_d = ST_NORMAL;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_q <= ST_NORMAL;
    else
      state_q <= state_d;
  end

  // operating count runs only while unblocked pick-up; blocking restarts it
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      op_cnt_q <= '0;
    else if (state_q != ST_START || block_in)
      op_cnt_q <= '0;
    else if (step_tick && pick)
      op_cnt_q <= op_cnt_q + 32'h1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      rel_cnt_q <= '0;
    else if ((state_q == ST_START && timing) || (state_q == ST_TRIP && pick)
             || state_q == ST_NORMAL || state_q == ST_BLOCKED)
      rel_cnt_q <= '0;
    else if (step_tick)
      rel_cnt_q <= rel_cnt_q + 32'h1;
  end

  // times in ms
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      exp_q <= '0;
      rem_q <= '0;
    end
    else
    begin
      exp_q <= (state_q == ST_START || state_q == ST_TRIP)
             ? 32'(op_dly_q * 32'(STEP_MS)) : 32'h0;
      rem_q <= (state_q == ST_START && op_dly_q > op_cnt_q)
             ? 32'((op_dly_q - op_cnt_q) * 32'(STEP_MS)) : 32'h0;
    end
  end

  // ==========================================================
  // outputs and interrupt
  assign start_out   = (state_q == ST_START);
  assign trip_out    = (state_q == ST_TRIP);
  assign blocked_out = (state_q == ST_BLOCKED);

  always_comb
  begin
    ev            = '0;
    ev[IRQ_START] = (state_d == ST_START) && (state_q != ST_START);
    ev[IRQ_TRIP]  = (state_d == ST_TRIP) && (state_q != ST_TRIP);
    ev[IRQ_BLOCK] = (state_d == ST_BLOCKED) && (state_q != ST_BLOCKED);
  end

  // set wins over a same-cycle clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      stat_q <= '0;
    else if (wr_en && awaddr_q == OFF_INT_STAT && wstrb_q[0])
      stat_q <= (stat_q & ~wdata_q[IRQ_W-1:0]) | ev;
    else
      stat_q <= stat_q | ev;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(stat_q & mask_q);
  end
endmodule // psc_stage

// ---- testbench/psc_stage_monitor.sv ----
/*
  Checker of the stage ports: bus answers, condition outputs, blocking.
  Assumes binding to psc_stage on one clock with a sync low reset.
*/
`timescale 1ns/1ns
module psc_stage_monitor
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        block_in,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        start_out,
  input wire logic        trip_out,
  input wire logic        blocked_out
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  // bus
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  property p_wr_resp; s_wr |-> ##2 s_axi_bvalid; endproperty
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write answer");
  a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
  a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
  // ==========================================================
  // condition
  property p_onehot; $onehot0({start_out, trip_out, blocked_out}); endproperty
  property p_trip_src; $rose(trip_out) |-> $past(start_out); endproperty
  property p_trip_end; $fell(trip_out) |-> !start_out && !blocked_out; endproperty
  property p_blk_src; $rose(blocked_out) |-> $past(block_in); endproperty
  property p_no_start; block_in && !start_out |=> !start_out; endproperty
  property p_blk_notrip; start_out && block_in |=> !trip_out; endproperty
  a_onehot: assert property (p_onehot) else $error("two states");
  a_trip_src: assert property (p_trip_src) else $error("trip not from start");
  a_trip_end: assert property (p_trip_end) else $error("trip left badly");
  a_blk_src: assert property (p_blk_src) else $error("blocked unasked");
  a_no_start: assert property (p_no_start) else $error("start while blocked");
  a_blk_notrip: assert property (p_blk_notrip) else $error("trip when blocked");
endmodule // psc_stage_monitor

// ---- testbench/psc_stage_tb_top.sv ----
/*
  Self-checking bench of psc_stage over AXI4-Lite and measurement inputs.
  Assumes a 10-cycle timing step, 25 MHz clock.
*/
`timescale 1ns/1ns
module psc_stage_tb_top;
  import psc_pkg::*;
  logic aclk = 0, aresetn = 0, block_in = 0;
  logic [95:0] meas_in = '0;
  logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic start_out, trip_out, blocked_out, irq;
  wire [3:0] pins = {irq, blocked_out, trip_out, start_out};
  int n_mismatch = 0, checks = 0, n;
  psc_stage #(.STEP_CYCLES(10)) psc_stage_i (.*);
  initial forever #20 aclk = ~aclk;
  // ==========================================================
  // shared tasks
  task print_verdict;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask
  task tmo(input int lim);
    if (n >= lim)
    begin
      $display("ERROR t=%0t seen %h exp %h", $time, n, lim);
      n_mismatch++;
      print_verdict;
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    // ready only once the answer is seen, so the answer must hold
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid && s_axi_bready) break;
      if (s_axi_bvalid) s_axi_bready <= 1;
    end
    s_axi_bready <= 0;
    tmo(50);
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (n = 0; n < 50; n++)
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && s_axi_rready) break;
      if (s_axi_rvalid) s_axi_rready <= 1;
    end
    s_axi_rready <= 0;
    rd = s_axi_rdata;
    rr = s_axi_rresp;
    tmo(50);
    if (e !== 32'hFFFF_FFFF) chk(rd, e);
  endtask
  task wp(input int k, input logic v);
    for (n = 0; n < 400; n++)
    begin
      @(posedge aclk);
      if (pins[k] === v) break;
    end
    tmo(400);
  endtask
  // ==========================================================
  // scenarios
  task t_reset;
    logic [7:0] b;
    rchk(OFF_CTRL, 32'h1);
    rchk(OFF_OP_DLY, OP_DEF);
    rchk(OFF_REL_DLY, REL_DEF);
    rchk(OFF_INT_MASK, 32'h0);
    rchk(OFF_COND, 32'h1);
    rchk(OFF_CALC_PU, PICKUP_DEF);
    for (int i = 0; i < 3; i++)
    begin
      b = 8'h80 + 8'(i * 32);
      rchk(b, SCALE_ONE);
      rchk(b + 8'h4, PICKUP_DEF);
      rchk(b + 8'h8, 32'h0);
      rchk(b + 8'hC, HYST_DEF);
    end
    rchk(8'h40, 32'h0);
    chk(rr, RESP_SLVERR);
    wr(OFF_COND, 32'h5);
    rchk(OFF_COND, 32'h1);
    for (int m = 0; m < 8; m++)
    begin
      wr(8'h88, 32'(m));
      rchk(8'h88, 32'(m));
    end
    wr(8'h88, 32'h0);
    // under modes above start timing on a zero input; let it release
    wp(0, 0);
    $display("done reset");
  endtask
  task t_scale;
    wr(8'h80, 32'h0002_0000);
    wr(8'h84, 32'hA);
    meas_in[31:0] <= 32'h5;
    rchk(8'h90, 32'hA);
    rchk(8'h94, 32'h0001_0000);
    chk(start_out, 0);
    $display("done scale");
  endtask
  task t_trip;
    wr(OFF_OP_DLY, 32'h2);
    wr(OFF_REL_DLY, 32'h1);
    meas_in[31:0] <= 32'h6;
    wp(0, 1);
    wp(1, 1);
    chk(n >= 8 && n <= 22, 1);
    rchk(OFF_COND, 32'h4);
    rchk(OFF_EXP_TIME, 32'hA);
    rchk(OFF_INT_STAT, 32'h3);
    // mask bit high lets the status bit through
    chk(irq, 0);
    wr(OFF_INT_MASK, 32'h7);
    rchk(OFF_COND, 32'h4);
    chk(irq, 1);
    wr(OFF_INT_STAT, 32'h3);
    rchk(OFF_INT_STAT, 32'h0);
    chk(irq, 0);
    wr(OFF_INT_MASK, 32'h0);
    meas_in[31:0] <= 32'h0;
    wp(1, 0);
    rchk(OFF_COND, 32'h1);
    $display("done trip");
  endtask
  task t_block;
    block_in <= 1;
    meas_in[31:0] <= 32'h6;
    wp(2, 1);
    rchk(OFF_COND, 32'h8);
    block_in <= 0;
    wp(0, 1);
    rchk(OFF_REM_TIME, 32'hFFFF_FFFF);
    chk(rd == 32'h5 || rd == 32'hA, 1);
    block_in <= 1;
    wp(2, 1);
    chk(trip_out, 0);
    // drop the pick-up while still blocked, else blocked falls into start
    meas_in[31:0] <= 32'h0;
    wp(2, 0);
    block_in <= 0;
    rchk(OFF_COND, 32'h1);
    $display("done block");
  endtask
  task t_count;
    wr(OFF_CTRL, 32'h2);
    meas_in[63:32] <= 32'd200;
    wp(0, 1);
    rchk(OFF_CALC_RAT, 32'h0002_0000);
    meas_in[63:32] <= 32'h0;
    wp(0, 0);
    wr(OFF_CTRL, 32'h1);
    meas_in[63:32] <= 32'd200;
    repeat (30) @(posedge aclk);
    chk(start_out, 0);
    wr(8'h88, 32'(CM_UNDER));
    wp(0, 1);
    meas_in[31:0] <= 32'h6;
    wp(0, 0);
    $display("done count");
  endtask
  initial
  begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    t_reset;
    t_scale;
    t_trip;
    t_block;
    t_count;
    print_verdict;
  end
endmodule // psc_stage_tb_top
bind psc_stage psc_stage_monitor psc_stage_monitor_i (.*);
